// *** logic/event_status_unit.sv ***
// event status reporting and per-channel unit and scale settings
module event_status_unit
  import status_pkg::*;
(
  // clock and reset
  input  wire logic                        clock_in,
  input  wire logic                        rst_n_in,
  // parsed command from the message interpreter
  input  wire logic                        cmd_valid_in,
  input  wire status_pkg::cmd_e            cmd_code_in,
  input  wire logic [status_pkg::CHAN_IDX_W-1:0] cmd_chan_in,
  input  wire logic [31:0]                 cmd_data_in,
  input  wire logic                        cmd_is_common_in,
  input  wire logic [3:0]                  subsys_sel_in,
  // event sources and answer header switch
  input  wire logic                        cmd_error_in,
  input  wire logic                        exec_error_in,
  input  wire logic                        dev_error_in,
  input  wire logic                        query_error_in,
  input  wire logic                        req_control_in,
  input  wire logic                        ops_pending_in,
  input  wire logic                        header_on_in,
  // answer
  output logic                             answer_valid_out,
  output status_pkg::answer_e              answer_kind_out,
  output logic [31:0]                      answer_data_out,
  output logic                             answer_header_out,
  output logic                             answer_plus_out,
  output logic                             answer_newline_out,
  // status and settings
  output logic [7:0]                       event_status_out,
  output logic [7:0]                       event_status_enable_mask_out,
  output logic [7:0]                       service_enable_mask_out,
  output logic                             event_summary_out,
  output logic                             error_reg_clear_out,
  output logic [3:0]                       subsys_sel_out,
  output logic [7:0]                       ext_probe_on_out,
  output logic [2*status_pkg::NUM_CHANNELS-1:0] unit_flat_out
);
  import status_pkg::*;

  logic [7:0]  event_status;
  logic [7:0]  event_status_enable_mask;
  logic [7:0]  service_enable_mask;
  logic [7:0]  next_event_status;
  logic [7:0]  event_sets;
  logic        op_done_armed;
  logic        op_done_fire;
  logic [3:0]  ext_probe_on;
  logic [3:0]  subsys_sel;
  logic        do_clear;
  logic        do_read;
  logic        ena_write;
  logic        sre_write;
  unit_e       unit_sel;
  logic [31:0] scale_sel;
  answer_e     next_answer_kind;
  logic [31:0] next_answer_data;
  unit_e       unit_of  [NUM_CHANNELS];
  logic [31:0] scale_of [NUM_CHANNELS];

  assign do_clear = cmd_valid_in && (cmd_code_in == CMD_CLEAR);
  assign do_read  = cmd_valid_in && (cmd_code_in == CMD_ASK_EVT);
  assign ena_write = cmd_valid_in && (cmd_code_in == CMD_SET_ENA);
  assign sre_write = cmd_valid_in && (cmd_code_in == CMD_SET_SRE);
  // settings of the addressed channel, for readback
  assign unit_sel  = unit_of[cmd_chan_in];
  assign scale_sel = scale_of[cmd_chan_in];

  // pending done request waits for operations to drain
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      op_done_armed <= 1'b0;
    end else if (cmd_valid_in && cmd_code_in == CMD_OP_DONE
                 && ops_pending_in) begin
      op_done_armed <= 1'b1;
    end else if (!ops_pending_in) begin
      op_done_armed <= 1'b0;
    end
  end

  assign op_done_fire = !ops_pending_in &&
    (op_done_armed || (cmd_valid_in && cmd_code_in == CMD_OP_DONE));

  always_comb begin
    event_sets                = 8'h00;
    event_sets[EVT_CMD_ERR]   = cmd_error_in;
    event_sets[EVT_EXEC_ERR]  = exec_error_in;
    event_sets[EVT_DEV_ERR]   = dev_error_in;
    event_sets[EVT_QUERY_ERR] = query_error_in;
    event_sets[EVT_REQ_CTRL]  = req_control_in;
    event_sets[EVT_OP_DONE]   = op_done_fire;
  end

  // sticky bits; a new event in the clearing cycle survives
  always_comb begin
    next_event_status = event_status;
    if (do_clear || do_read) begin
      next_event_status = 8'h00;
    end
    next_event_status = (next_event_status | event_sets)
                        & EVT_LIVE_MASK;
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      event_status <= EVT_RESET_VAL;
    end else begin
      event_status <= next_event_status;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      event_status_enable_mask <= ENABLE_RESET;
    end else if (ena_write) begin
      event_status_enable_mask <= cmd_data_in[7:0] & EVT_LIVE_MASK;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      service_enable_mask <= SRE_RESET;
    end else if (sre_write) begin
      service_enable_mask <= cmd_data_in[7:0];
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      event_summary_out <= 1'b0;
    end else begin
      event_summary_out <=
        |(next_event_status & event_status_enable_mask);
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      error_reg_clear_out <= 1'b0;
    end else begin
      error_reg_clear_out <= do_clear;
    end
  end

  // common commands leave the selection untouched
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      subsys_sel <= 4'h0;
    end else if (cmd_valid_in && !cmd_is_common_in) begin
      subsys_sel <= subsys_sel_in;
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CHANNELS; ch++) begin : g_chan
      always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          ext_probe_on[ch] <= 1'b0;
        end else if (cmd_valid_in && cmd_code_in == CMD_EXT_MODE
                     && cmd_chan_in == CHAN_IDX_W'(ch)) begin
          ext_probe_on[ch] <= cmd_data_in[0];
        end
      end

      always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          unit_of[ch] <= UNIT_VOLT;
        end else if (cmd_valid_in && cmd_chan_in == CHAN_IDX_W'(ch)
                     && (cmd_code_in == CMD_SET_UNIT
                     || (cmd_code_in == CMD_EXT_UNIT
                         && ext_probe_on[ch]))) begin
          unit_of[ch] <= unit_e'(cmd_data_in[1:0]);
        end
      end

      always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          scale_of[ch] <= SCALE_RESET;
        end else if (cmd_valid_in && cmd_code_in == CMD_SET_SCALE
                     && cmd_chan_in == CHAN_IDX_W'(ch)) begin
          scale_of[ch] <= cmd_data_in;
        end
      end

      assign unit_flat_out[2*ch +: 2] = unit_of[ch];
    end
  endgenerate

  // answer kind picked from the query in flight
  always_comb begin
    next_answer_kind = ANS_NONE;
    if (cmd_valid_in) begin
      case (cmd_code_in)
        CMD_ASK_UNIT:  next_answer_kind = ANS_UNIT;
        CMD_ASK_SCALE: next_answer_kind = ANS_SCALE;
        CMD_ASK_ENA:   next_answer_kind = ANS_ENABLE;
        CMD_ASK_EVT:   next_answer_kind = ANS_EVENT;
        default:       next_answer_kind = ANS_NONE;
      endcase
    end
  end

  // payload of the answer; held between answers
  always_comb begin
    next_answer_data = answer_data_out;
    case (next_answer_kind)
      ANS_UNIT: begin
        next_answer_data = {30'h0, unit_sel};
      end
      ANS_SCALE: begin
        next_answer_data = scale_sel;
      end
      ANS_ENABLE: begin
        next_answer_data = {24'h0, event_status_enable_mask};
      end
      ANS_EVENT: begin
        next_answer_data = {24'h0, event_status};
      end
      default: begin
        next_answer_data = answer_data_out;
      end
    endcase
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      answer_valid_out <= 1'b0;
    end else begin
      answer_valid_out <= (next_answer_kind != ANS_NONE);
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      answer_kind_out <= ANS_NONE;
    end else begin
      answer_kind_out <= next_answer_kind;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      answer_data_out <= 32'h00000000;
    end else begin
      answer_data_out <= next_answer_data;
    end
  end

  // common answers never carry a header
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      answer_header_out <= 1'b0;
    end else begin
      answer_header_out <= header_on_in
        && (next_answer_kind inside {ANS_UNIT, ANS_SCALE});
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      answer_plus_out <= 1'b0;
    end else begin
      answer_plus_out <= (next_answer_kind == ANS_ENABLE);
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      answer_newline_out <= 1'b0;
    end else begin
      answer_newline_out <= 1'b1;
    end
  end

  assign event_status_out             = event_status;
  assign event_status_enable_mask_out = event_status_enable_mask;
  assign service_enable_mask_out      = service_enable_mask;
  assign subsys_sel_out               = subsys_sel;
  assign ext_probe_on_out             = {4'h0, ext_probe_on};
endmodule : event_status_unit

// *** logic/status_pkg.sv ***
// shared constants for the event status and channel unit block
package status_pkg;
  localparam int          NUM_CHANNELS   = 4;
  localparam int          CHAN_IDX_W     = 2;
  // event status bit positions
  localparam int          EVT_POWER_ON   = 7;
  localparam int          EVT_UNUSED     = 6;
  localparam int          EVT_CMD_ERR    = 5;
  localparam int          EVT_EXEC_ERR   = 4;
  localparam int          EVT_DEV_ERR    = 3;
  localparam int          EVT_QUERY_ERR  = 2;
  localparam int          EVT_REQ_CTRL   = 1;
  localparam int          EVT_OP_DONE    = 0;
  localparam logic [7:0]  EVT_LIVE_MASK  = 8'hBF;
  localparam logic [7:0]  EVT_RESET_VAL  = 8'h80;
  localparam logic [7:0]  ENABLE_RESET   = 8'h00;
  localparam logic [31:0] SCALE_RESET    = 32'h3F800000;
  localparam logic [7:0]  SRE_RESET      = 8'h00;

  typedef enum logic [1:0] {
    UNIT_VOLT    = 2'b00,
    UNIT_AMPERE  = 2'b01,
    UNIT_WATT    = 2'b10,
    UNIT_UNKNOWN = 2'b11
  } unit_e;

  typedef enum logic [3:0] {
    CMD_NONE      = 4'h0,
    CMD_SET_UNIT  = 4'h1,
    CMD_EXT_UNIT  = 4'h2,
    CMD_ASK_UNIT  = 4'h3,
    CMD_SET_SCALE = 4'h4,
    CMD_ASK_SCALE = 4'h5,
    CMD_CLEAR     = 4'h6,
    CMD_SET_ENA   = 4'h7,
    CMD_ASK_ENA   = 4'h8,
    CMD_ASK_EVT   = 4'h9,
    CMD_OP_DONE   = 4'hA,
    CMD_SET_SRE   = 4'hB,
    CMD_EXT_MODE  = 4'hC
  } cmd_e;

  // answer kinds: the formatter adds sign or newline as marked
  typedef enum logic [2:0] {
    ANS_NONE    = 3'b000,
    ANS_UNIT    = 3'b001,
    ANS_SCALE   = 3'b010,
    ANS_ENABLE  = 3'b011,
    ANS_EVENT   = 3'b100
  } answer_e;
endpackage : status_pkg

// *** sim/event_status_unit_tb_top.sv ***
// bench for the event status and channel unit block
module event_status_unit_tb_top import status_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock_in, rst_n_in, cmd_valid_in, cmd_is_common_in;
  logic        cmd_error_in, exec_error_in, dev_error_in, query_error_in;
  logic        req_control_in, ops_pending_in, header_on_in;
  logic        answer_valid_out, answer_header_out, answer_plus_out;
  logic        answer_newline_out, event_summary_out, error_reg_clear_out;
  logic [1:0]  cmd_chan_in;
  logic [3:0]  subsys_sel_in, subsys_sel_out;
  logic [7:0]  event_status_out, event_status_enable_mask_out;
  logic [7:0]  service_enable_mask_out, ext_probe_on_out, unit_flat_out;
  logic [31:0] cmd_data_in, answer_data_out, d;
  cmd_e        cmd_code_in;
  answer_e     answer_kind_out;
  int          failures, check_count;
  event_status_unit dut (.*);
  host_model host (.clock_in(clock_in), .cmd_valid_out(cmd_valid_in),
    .cmd_code_out(cmd_code_in), .cmd_chan_out(cmd_chan_in),
    .cmd_data_out(cmd_data_in), .cmd_is_common_out(cmd_is_common_in));
  task automatic check(input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic pulse(ref logic sig);
    @(negedge clock_in);
    sig = 1'b1;
    @(negedge clock_in);
    sig = 1'b0;
  endtask : pulse
  task automatic ask(input cmd_e c, input logic [1:0] ch);
    host.send(c, ch, 32'h0);
    // answer stands from the taken edge to the next one
    d = answer_data_out;
  endtask : ask
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    clock_in = 1'b0;
    forever #2.5 clock_in = ~clock_in;
  end
  initial begin
    repeat (2000) @(posedge clock_in);
    failures++;
    tally_and_finish();
  end
  initial begin
    {rst_n_in, cmd_error_in, exec_error_in, dev_error_in} = '0;
    {query_error_in, req_control_in, ops_pending_in, subsys_sel_in} = '0;
    {failures, check_count} = '0;
    header_on_in = 1'b1;
    repeat (5) @(negedge clock_in);
    rst_n_in = 1'b1;
    check(event_status_out, 8'h80);
    ask(CMD_ASK_EVT, 2'd0);
    check(d, 32'd128);
    check(answer_valid_out, 1'b1);
    check(answer_kind_out, ANS_EVENT);
    check(event_status_out, 8'h00);
    @(negedge clock_in);
    check(answer_valid_out, 1'b0);
    $display("test power on read done");
    for (int ch = 0; ch < 4; ch++) host.send(CMD_SET_UNIT, 2'(ch), 32'(3 - ch));
    check(unit_flat_out, 8'h1B);
    ask(CMD_ASK_UNIT, 2'd1);
    check(d[1:0], UNIT_WATT);
    check(answer_kind_out, ANS_UNIT);
    check(answer_header_out, 1'b1);
    host.send(CMD_EXT_UNIT, 2'd3, 32'h1);
    check(unit_flat_out, 8'h1B);
    host.send(CMD_EXT_MODE, 2'd3, 32'h1);
    check(ext_probe_on_out, 8'h08);
    host.send(CMD_EXT_UNIT, 2'd3, 32'h1);
    check(unit_flat_out, 8'h5B);
    $display("test units done");
    subsys_sel_in = 4'h5;
    host.send(CMD_SET_SCALE, 2'd2, 32'h3F000000);
    ask(CMD_ASK_SCALE, 2'd2);
    check(d, 32'h3F000000);
    check(answer_newline_out, 1'b1);
    check(answer_plus_out, 1'b0);
    $display("test scale done");
    host.send(CMD_SET_ENA, 2'd0, 32'h1FF);
    check(event_status_enable_mask_out, 8'hBF);
    ask(CMD_ASK_ENA, 2'd0);
    check(d, 32'h000000BF);
    check(answer_plus_out, 1'b1);
    check(answer_header_out, 1'b0);
    host.send(CMD_SET_SRE, 2'd0, 32'h42);
    check(service_enable_mask_out, 8'h42);
    check(event_status_enable_mask_out, 8'hBF);
    $display("test masks done");
    host.send(CMD_SET_ENA, 2'd0, 32'h20);
    pulse(exec_error_in);
    @(negedge clock_in);
    check(event_summary_out, 1'b0);
    pulse(cmd_error_in);
    @(negedge clock_in);
    check(event_summary_out, 1'b1);
    ask(CMD_ASK_EVT, 2'd0);
    check(d, 32'h30);
    pulse(dev_error_in);
    pulse(query_error_in);
    pulse(req_control_in);
    ask(CMD_ASK_EVT, 2'd0);
    check(d, 32'h0E);
    $display("test events done");
    ops_pending_in = 1'b1;
    host.send(CMD_OP_DONE, 2'd0, 32'h0);
    repeat (3) @(negedge clock_in);
    check(event_status_out[0], 1'b0);
    ops_pending_in = 1'b0;
    repeat (2) @(negedge clock_in);
    check(event_status_out[0], 1'b1);
    pulse(cmd_error_in);
    subsys_sel_in = 4'h9;
    host.send(CMD_CLEAR, 2'd0, 32'h0);
    check(error_reg_clear_out, 1'b1);
    check(event_status_out, 8'h00);
    check(subsys_sel_out, 4'h5);
    $display("test clear done");
    tally_and_finish();
  end
endmodule : event_status_unit_tb_top

// *** sim/host_model.sv ***
// remote controller model that issues parsed commands
module host_model
  import status_pkg::*;
(
  input  wire logic        clock_in,
  output logic             cmd_valid_out,
  output status_pkg::cmd_e cmd_code_out,
  output logic [1:0]       cmd_chan_out,
  output logic [31:0]      cmd_data_out,
  output logic             cmd_is_common_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {cmd_valid_out, cmd_chan_out, cmd_data_out, cmd_is_common_out} = '0;
    cmd_code_out = CMD_NONE;
  end
  task automatic send(input cmd_e c, input logic [1:0] ch,
                      input logic [31:0] v);
    @(negedge clock_in);
    cmd_valid_out = 1'b1;
    cmd_code_out = c;
    cmd_chan_out = ch;
    cmd_data_out = (c == CMD_SET_ENA) ? {24'h0, v[7:0]} : v;
    cmd_is_common_out = c inside {CMD_CLEAR, CMD_SET_ENA, CMD_ASK_ENA,
                                  CMD_ASK_EVT, CMD_OP_DONE, CMD_SET_SRE};
    @(negedge clock_in);
    cmd_valid_out = 1'b0;
    // released data no longer holds its value
    cmd_data_out = ~cmd_data_out;
  endtask : send
endmodule : host_model

// *** sim/status_check_sva.sv ***
// assertions on the event status block ports
module status_check
  import status_pkg::*;
(
  input wire logic                clock_in, rst_n_in,
  input wire logic                cmd_valid_in, cmd_error_in,
  input wire status_pkg::cmd_e    cmd_code_in,
  input wire logic [31:0]         cmd_data_in,
  input wire logic                answer_valid_out, answer_header_out,
  input wire logic                answer_plus_out, event_summary_out,
  input wire status_pkg::answer_e answer_kind_out,
  input wire logic [7:0]          event_status_out,
  input wire logic [7:0]          event_status_enable_mask_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] live;
  assign live = event_status_out & event_status_enable_mask_out;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_taken(cmd_e c); cmd_valid_in && cmd_code_in == c; endsequence

  a_enable_load: assert property (
    s_taken(CMD_SET_ENA) |=> event_status_enable_mask_out ==
    ($past(cmd_data_in) & 32'h000000BF)) else $error("mask load");
  a_plus_enable: assert property (
    answer_valid_out |-> answer_plus_out == (answer_kind_out == ANS_ENABLE))
    else $error("plus sign");
  a_common_nohead: assert property (
    answer_valid_out && answer_kind_out inside {ANS_ENABLE, ANS_EVENT}
    |-> !answer_header_out) else $error("header on common answer");
  a_bit6_zero: assert property (
    !event_status_out[6] && !event_status_enable_mask_out[6])
    else $error("bit six set");
  a_cmd_err_sets: assert property (
    cmd_error_in |=> event_status_out[5]) else $error("command error lost");
  a_sticky_bits: assert property (
    !(cmd_valid_in && cmd_code_in inside {CMD_CLEAR, CMD_ASK_EVT}) |=>
    (event_status_out & $past(event_status_out)) == $past(event_status_out))
    else $error("event bit dropped");
  a_read_clears: assert property (
    s_taken(CMD_ASK_EVT) ##0 !cmd_error_in |=> event_status_out[7:5] == 3'h0)
    else $error("read did not clear");
  a_summary_on: assert property (
    (live != 8'h00) [*2] |-> event_summary_out) else $error("summary low");
endmodule : status_check

bind event_status_unit status_check chk (.*);
